//--- memdec.v
// Program/data memory decoder with dual data pointer and stretched external data moves.
`timescale 1ns/10ps
`include "memdec_defines.vh"
module memdec (
  input  wire        ref_clk_i,       // Core clock.
  input  wire        rst_i,           // Async reset, high.
  input  wire        sfr_wr_i,        // Special register write strobe.
  input  wire        sfr_rd_i,        // Special register read strobe.
  input  wire [7:0]  sfr_addr_i,      // Special register address.
  input  wire [7:0]  sfr_wdata_i,     // Special register write data.
  input  wire        rom_limit_wr_i,  // Write strobe for the ROM limit register.
  input  wire        timed_access_i,  // Timed-access window open.
  output reg  [7:0]  sfr_rdata_o,     // Special register read data.
  input  wire [15:0] fetch_addr_i,    // Program fetch address.
  input  wire        fetch_req_i,     // Program fetch request.
  output wire        fetch_ext_o,     // Fetch goes off-chip.
  output wire        program_store_strobe_n_o, // Program strobe, low active.
  input  wire        external_access_n_i,      // External access pin.
  input  wire        dp_load_i,       // Load selected pointer.
  input  wire [15:0] dp_load_val_i,   // Pointer load value.
  input  wire        dp_inc_i,        // Increment selected pointer.
  output wire [15:0] dp_active_o,     // Selected pointer value.
  input  wire        xmove_start_i,   // Start an external data move.
  input  wire        xmove_we_i,      // Move is a write.
  input  wire [15:0] xmove_addr_i,    // Move address.
  input  wire [7:0]  xmove_wdata_i,   // Move write data.
  output reg         xmove_busy_o,    // Move in progress.
  output reg         xmove_done_o,    // Move finished pulse.
  output reg  [7:0]  xmove_rdata_o,   // Move read data.
  input  wire [2:0]  security_lock_bits_i, // Programmed lock bits.
  output reg  [7:0]  muxed_low_port_o,     // Address low / data out.
  output reg         muxed_low_port_oe_n_o, // Low while driving.
  input  wire [7:0]  muxed_low_port_i,      // Data in.
  output reg  [7:0]  high_address_port_o,   // Address high byte.
  output reg         bus_active_o,          // Ports serve as bus.
  output reg         addr_latch_o,          // Address latch enable.
  output reg         rd_strobe_n_o,         // Read strobe, low active.
  output reg         wr_strobe_n_o          // Write strobe, low active.
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_SETUP = 3'h2;
  localparam ST_STRB  = 3'h3;
  localparam ST_HOLD  = 3'h4;
  localparam ST_INT   = 3'h5;

  reg [2:0]  rom_limit_code;
  reg [7:0]  power_management;
  reg [7:0]  clock_control;
  reg [15:0] dp0;
  reg [15:0] dp1;
  reg        pointer_select_bit;
  reg [7:0]  sram [0:1023];
  reg [2:0]  ea_sync;
  reg        ea_n;
  reg [`STATE_W-1:0] state;
  reg [5:0]  cnt;
  reg [2:0]  mv_stretch;
  reg        mv_we;
  reg [15:0] mv_addr;
  reg [7:0]  mv_wdata;
  reg        mv_int;
  reg        mv_lock;
  reg [16:0] rom_top;

  ////////////////////////////////////////////////////////////////////////////
  // Program space decode.
  always @* begin
    case (rom_limit_code) // [RULE1]
      3'h0:    rom_top = 17'h00000;
      3'h1:    rom_top = 17'h00400;
      3'h2:    rom_top = 17'h00800;
      3'h3:    rom_top = 17'h01000;
      3'h4:    rom_top = 17'h02000;
      3'h5:    rom_top = 17'h04000;
      default: rom_top = 17'h04000;
    endcase
  end

  // Combinational so a new limit affects the very next fetch. [RULE5]
  assign fetch_ext_o = ea_n | ({1'b0, fetch_addr_i} >= rom_top); // [RULE2] [RULE7] [RULE19]
  assign program_store_strobe_n_o = ~(fetch_req_i & fetch_ext_o); // [RULE9]
  assign dp_active_o = pointer_select_bit ? dp1 : dp0; // [RULE22]

  // The pin is asynchronous; taken once two later stages agree.
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ea_sync <= 3'h7;
      ea_n    <= 1'b0;
    end else begin
      ea_sync <= {ea_sync[1:0], external_access_n_i};
      if (ea_sync[2] == ea_sync[1])
        ea_n <= ~ea_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Special registers and data pointers.
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rom_limit_code     <= `RST_ROM_LIMIT; // [RULE3]
      power_management   <= `RST_PWR_MGMT; // [RULE11]
      clock_control      <= `RST_CLK_CTRL; // [RULE16]
      dp0                <= 16'h0000;
      dp1                <= 16'h0000;
      pointer_select_bit <= 1'b0;
    end else begin
      if (rom_limit_wr_i && timed_access_i) // [RULE4]
        rom_limit_code <= sfr_wdata_i[2:0];
      if (sfr_wr_i) begin
        case (sfr_addr_i)
          `ADDR_DP0_LO:   dp0[7:0]  <= sfr_wdata_i;
          `ADDR_DP0_HI:   dp0[15:8] <= sfr_wdata_i;
          `ADDR_DP1_LO:   dp1[7:0]  <= sfr_wdata_i; // [RULE20]
          `ADDR_DP1_HI:   dp1[15:8] <= sfr_wdata_i;
          `ADDR_PTR_SEL:  pointer_select_bit <= sfr_wdata_i[0]; // [RULE21]
          `ADDR_CLK_CTRL: clock_control <= sfr_wdata_i;
          `ADDR_PWR_MGMT: power_management <= sfr_wdata_i;
          default: ;
        endcase
      end else if (dp_load_i) begin
        if (pointer_select_bit) dp1 <= dp_load_val_i; // [RULE22]
        else dp0 <= dp_load_val_i;
      end else if (dp_inc_i) begin
        if (pointer_select_bit) dp1 <= dp1 + 16'h0001;
        else dp0 <= dp0 + 16'h0001;
      end
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i) begin
      case (sfr_addr_i)
        `ADDR_DP0_LO:   sfr_rdata_o <= dp0[7:0];
        `ADDR_DP0_HI:   sfr_rdata_o <= dp0[15:8];
        `ADDR_DP1_LO:   sfr_rdata_o <= dp1[7:0];
        `ADDR_DP1_HI:   sfr_rdata_o <= dp1[15:8];
        `ADDR_PTR_SEL:  sfr_rdata_o <= {7'h00, pointer_select_bit}; // [RULE21]
        `ADDR_CLK_CTRL: sfr_rdata_o <= clock_control;
        `ADDR_PWR_MGMT: sfr_rdata_o <= power_management;
        default:        sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External data move sequencer; one machine cycle is four clocks.
  // Stretch is captured at start so later writes wait for the next move.
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state                 <= ST_IDLE;
      cnt                   <= 6'h00;
      mv_stretch            <= `RST_STRETCH;
      mv_we                 <= 1'b0;
      mv_addr               <= 16'h0000;
      mv_wdata              <= 8'h00;
      mv_int                <= 1'b0;
      mv_lock               <= 1'b0;
      xmove_busy_o          <= 1'b0;
      xmove_done_o          <= 1'b0;
      xmove_rdata_o         <= 8'h00;
      muxed_low_port_o      <= 8'h00;
      muxed_low_port_oe_n_o <= 1'b1;
      high_address_port_o   <= 8'h00;
      bus_active_o          <= 1'b0;
      addr_latch_o          <= 1'b0;
      rd_strobe_n_o         <= 1'b1;
      wr_strobe_n_o         <= 1'b1;
    end else begin
      xmove_done_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (xmove_start_i) begin
            mv_stretch   <= clock_control[2:0]; // [RULE23] [RULE15]
            mv_we        <= xmove_we_i;
            mv_addr      <= xmove_addr_i;
            mv_wdata     <= xmove_wdata_i;
            xmove_busy_o <= 1'b1;
            cnt          <= 6'h00;
            // Map decode. [RULE10]
            mv_int  <= (power_management[1:0] == `MAP_SRAM_EXT ||
                        power_management[1:0] == `MAP_SRAM_LOCK) &&
                       (xmove_addr_i <= `SRAM_TOP);
            mv_lock <= (power_management[1:0] == `MAP_SRAM_LOCK) &&
                       (xmove_addr_i > `SRAM_TOP);
            if (power_management[1:0] == `MAP_ALL_EXT ||
                (power_management[1:0] == `MAP_SRAM_EXT && xmove_addr_i > `SRAM_TOP)) begin
              state               <= ST_ADDR;
              bus_active_o        <= 1'b1; // [RULE8]
              addr_latch_o        <= 1'b1;
              high_address_port_o <= xmove_addr_i[15:8];
              muxed_low_port_o    <= xmove_addr_i[7:0];
              muxed_low_port_oe_n_o <= 1'b0;
            end else
              state <= ST_INT;
          end
        end
        ST_INT: begin
          // On-chip or no-bus moves: two machine cycles total. [RULE14]
          cnt <= cnt + 6'h01;
          if (cnt == 6'h06) begin
            if (mv_int && mv_we)
              sram[mv_addr[9:0]] <= mv_wdata; // [RULE13]
            else if (mv_int)
              xmove_rdata_o <= sram[mv_addr[9:0]];
            else if (mv_lock && mv_addr == `LOCK_STAT_ADDR && !mv_we)
              xmove_rdata_o <= {5'h00, security_lock_bits_i}; // [RULE12]
            else
              xmove_rdata_o <= 8'h00;
            state        <= ST_IDLE;
            xmove_busy_o <= 1'b0;
            xmove_done_o <= 1'b1;
          end
        end
        ST_ADDR: begin
          addr_latch_o <= 1'b0;
          cnt          <= cnt + 6'h01;
          // The address phase is padded so a move spans stretch plus two machine cycles.
          if (cnt == `ADDR_PAD) begin // [RULE15]
            cnt   <= 6'h00;
            state <= ST_SETUP;
            if (mv_we)
              muxed_low_port_o <= mv_wdata;
            else
              muxed_low_port_oe_n_o <= 1'b1;
          end
        end
        ST_SETUP: begin
          cnt <= cnt + 6'h01;
          if (mv_stretch == 3'h0 || cnt == 6'h01) begin // [RULE18]
            state         <= ST_STRB;
            cnt           <= 6'h00;
            rd_strobe_n_o <= mv_we;
            wr_strobe_n_o <= ~mv_we;
          end
        end
        ST_STRB: begin
          cnt <= cnt + 6'h01;
          // Width 2 at stretch 0, else four clocks per stretch step. [RULE17]
          if (cnt == ((mv_stretch == 3'h0) ? 6'h01 : {1'b0, mv_stretch, 2'h0} - 6'h01)) begin
            if (!mv_we)
              xmove_rdata_o <= muxed_low_port_i;
            rd_strobe_n_o <= 1'b1;
            wr_strobe_n_o <= 1'b1;
            cnt           <= 6'h00;
            state         <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt <= cnt + 6'h01;
          if (mv_stretch == 3'h0 || cnt == 6'h01) begin // [RULE18]
            muxed_low_port_oe_n_o <= 1'b1;
            bus_active_o <= 1'b0;
            xmove_busy_o <= 1'b0;
            xmove_done_o <= 1'b1;
            state        <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- memdec_defines.vh
// Constants for the memory map decoder and stretched external data move timing.
// Notes on behaviour
// RULE1: Limit codes map 0,1,2,4,8,16kB; 110/111 reserved.
// RULE2: Fetches above limit go external; zero limit all.
// RULE3: Reset limit is 16kB.
// RULE4: Limit writes need timed-access qualifier.
// RULE5: New limit acts on next fetch.
// RULE6: Software changes limit from stable-side code.
// RULE7: External access pin low forces external fetches.
// RULE8: Low port muxes address/data, high port address.
// RULE9: Program strobe low during external fetches.
// RULE10: Map select bits choose on-chip/external data decode.
// RULE11: Data SRAM disabled by default; all external.
// RULE12: Lock status read returns lock bits 2-0.
// RULE13: Map changes keep SRAM contents.
// RULE14: On-chip data moves take two machine cycles.
// RULE15: External move lasts stretch plus two cycles.
// RULE16: Reset stretch value is one.
// RULE17: Strobe 2 clocks, then 4 per step.
// RULE18: Nonzero stretch adds one clock setup, hold.
// RULE19: Stretch never affects program fetches.
// RULE20: Second pointer at 84h/85h; 86h lsb selects.
// RULE21: Select register upper bits read zero.
// RULE22: Pointer operations use the selected pointer.
// RULE23: Stretch latched at move start only.
`ifndef MEMDEC_DEFINES_VH
`define MEMDEC_DEFINES_VH
`define ADDR_DP0_LO      8'h82
`define ADDR_DP0_HI      8'h83
`define ADDR_DP1_LO      8'h84
`define ADDR_DP1_HI      8'h85
`define ADDR_PTR_SEL     8'h86
`define ADDR_CLK_CTRL    8'h8E
`define ADDR_PWR_MGMT    8'hC4
`define RST_ROM_LIMIT    3'h5
`define RST_STRETCH      3'h1
`define RST_PWR_MGMT     8'h00
`define RST_CLK_CTRL     8'h01
`define SRAM_TOP         16'h03FF
`define LOCK_STAT_ADDR   16'hFFFC
`define MAP_ALL_EXT      2'h0
`define MAP_SRAM_EXT     2'h1
`define MAP_SRAM_LOCK    2'h3
`define CLK_PER_MC       2'h3
`define INT_MOVE_MC      4'h2
`define ADDR_PAD         6'h02
`define STATE_W          3
`endif

//--- memdec_assertions.sv
// Concurrent checks on the memory decoder ports.
`timescale 1ns/10ps
`include "memdec_defines.vh"
module memdec_assertions (
  input logic        ref_clk_i,                // Clock.
  input logic        rst_i,                    // Reset.
  input logic        sfr_rd_i,                 // Register read.
  input logic [7:0]  sfr_addr_i,               // Register address.
  input logic [7:0]  sfr_rdata_o,              // Register data.
  input logic [15:0] fetch_addr_i,             // Fetch address.
  input logic        fetch_req_i,              // Fetch request.
  input logic        fetch_ext_o,              // Fetch off-chip.
  input logic        program_store_strobe_n_o, // Program strobe.
  input logic        external_access_n_i,      // Access pin.
  input logic        xmove_busy_o,             // Move busy.
  input logic        xmove_done_o,             // Move done.
  input logic        muxed_low_port_oe_n_o,    // Low port enable.
  input logic        bus_active_o,             // Bus mode.
  input logic        addr_latch_o,             // Address latch.
  input logic        rd_strobe_n_o,            // Read strobe.
  input logic        wr_strobe_n_o             // Write strobe.
);
  logic [5:0] low_cnt;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Counts strobe-low clocks, since the longest width is past repetition limits.
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i)
      low_cnt <= 6'h00;
    else if (!rd_strobe_n_o || !wr_strobe_n_o)
      low_cnt <= low_cnt + 6'h01;
    else
      low_cnt <= 6'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_store_match: assert property (program_store_strobe_n_o == !(fetch_req_i && fetch_ext_o))
    else $error("program strobe disagrees with fetch");
  a_high_ext: assert property (fetch_addr_i[15:14] != 2'h0 |-> fetch_ext_o)
    else $error("fetch above 16kB stayed on-chip");
  a_pin_force: assert property ((!external_access_n_i) [*5] |-> fetch_ext_o)
    else $error("access pin low did not force off-chip fetch");
  a_rd_release: assert property (!rd_strobe_n_o |-> muxed_low_port_oe_n_o && bus_active_o)
    else $error("low port driven during read strobe");
  a_wr_drive: assert property (!wr_strobe_n_o |-> !muxed_low_port_oe_n_o && bus_active_o)
    else $error("low port not driven during write strobe");
  a_ale_bus: assert property (addr_latch_o |-> bus_active_o)
    else $error("address latch outside bus mode");
  a_strobe_busy: assert property (!(rd_strobe_n_o && wr_strobe_n_o) |-> xmove_busy_o)
    else $error("strobe outside a move");
  a_strobe_max: assert property (low_cnt <= 6'd28)
    else $error("strobe longer than 28 clocks");
  a_move_min: assert property ($rose(xmove_busy_o) |-> !xmove_done_o [*3])
    else $error("move finished too early");
  a_move_max: assert property ($rose(xmove_busy_o) |-> ##[1:40] xmove_done_o)
    else $error("move did not finish");
  a_sel_zero: assert property (sfr_rd_i && sfr_addr_i == `ADDR_PTR_SEL |=> sfr_rdata_o[7:1] == 7'h00)
    else $error("select upper bits not zero");
  c_ext_rd: cover property (!rd_strobe_n_o);
  c_ext_wr: cover property (!wr_strobe_n_o);
  c_fetch_ext: cover property (fetch_req_i && fetch_ext_o);
endmodule

//--- memdec_ext_mem.sv
// External data memory on the multiplexed bus.
`timescale 1ns/10ps
module ext_data_mem (
  input  logic       ref_clk_i,           // Clock.
  input  logic [7:0] muxed_low_port_o,    // Address low / write data.
  input  logic [7:0] high_address_port_o, // Address high.
  input  logic       addr_latch_o,        // Latch enable.
  input  logic       rd_strobe_n_o,       // Read strobe.
  input  logic       wr_strobe_n_o,       // Write strobe.
  output logic [7:0] muxed_low_port_i     // Read data.
);
  logic [7:0] mem [0:255];
  logic [7:0] lat_lo;
  logic [7:0] last;
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0];
  end
  always @(posedge ref_clk_i) begin
    if (addr_latch_o)
      lat_lo <= muxed_low_port_o;
    if (!wr_strobe_n_o)
      mem[lat_lo ^ high_address_port_o] <= muxed_low_port_o;
    if (!rd_strobe_n_o)
      last <= mem[lat_lo ^ high_address_port_o];
  end
  // Outside the read strobe the bus shows the inverse, so a stale byte cannot pass.
  assign muxed_low_port_i = !rd_strobe_n_o ? mem[lat_lo ^ high_address_port_o] : ~last;
endmodule

//--- memdec_tb.sv
// Self-checking bench for the memory decoder.
`timescale 1ns/10ps
`include "memdec_defines.vh"
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); \
  end \
end
module memdec_tb;
  logic ref_clk_i, rst_i, sfr_wr_i, sfr_rd_i, rom_limit_wr_i, timed_access_i;
  logic fetch_req_i, fetch_ext_o, program_store_strobe_n_o, external_access_n_i;
  logic dp_load_i, dp_inc_i, xmove_start_i, xmove_we_i, xmove_busy_o, xmove_done_o;
  logic muxed_low_port_oe_n_o, bus_active_o, addr_latch_o, rd_strobe_n_o, wr_strobe_n_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, xmove_wdata_i, xmove_rdata_o;
  logic [7:0] muxed_low_port_o, muxed_low_port_i, high_address_port_o, rd;
  logic [15:0] fetch_addr_i, dp_load_val_i, dp_active_o, xmove_addr_i;
  logic [2:0] security_lock_bits_i;
  logic [19:0] rows [10] = '{20'h53FFF, 20'hD4000, 20'h80000, 20'h103FF, 20'h90400,
                             20'h30FFF, 20'hC2000, 20'h207FF, 20'hA0800, 20'h63FFF};
  int error_cnt = 0, checks = 0, cyc, wid;
  memdec dut (.*);
  ext_data_mem mem (.*);
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task step;
    @(posedge ref_clk_i);
    #1;
  endtask
  task sfr_w(input [7:0] a, input [7:0] d);
    {sfr_wr_i, sfr_addr_i, sfr_wdata_i} = {1'b1, a, d};
    step();
    sfr_wr_i = 1'b0;
    step();
  endtask
  task sfr_r(input [7:0] a);
    {sfr_rd_i, sfr_addr_i} = {1'b1, a};
    step();
    sfr_rd_i = 1'b0;
    rd = sfr_rdata_o;
    step();
  endtask
  task set_limit(input [2:0] c, input bit ta);
    {rom_limit_wr_i, timed_access_i, sfr_wdata_i} = {1'b1, ta, 5'h00, c};
    step();
    {rom_limit_wr_i, timed_access_i} = 2'h0;
    step();
  endtask
  task fchk(input [15:0] a, input bit ext);
    {fetch_req_i, fetch_addr_i} = {1'b1, a};
    #1;
    `CHK("fetch_ext", ext, fetch_ext_o)
    `CHK("store_strobe", !ext, program_store_strobe_n_o)
    fetch_req_i = 1'b0;
    #1;
  endtask
  task move(input bit we, input [15:0] a, input [7:0] wd);
    step();
    {xmove_start_i, xmove_we_i, xmove_addr_i, xmove_wdata_i} = {1'b1, we, a, wd};
    step();
    xmove_start_i = 1'b0;
    cyc = 1;
    wid = 0;
    while (xmove_done_o !== 1'b1 && cyc < 60) begin
      if (rd_strobe_n_o === 1'b0 || wr_strobe_n_o === 1'b0)
        wid++;
      step();
      cyc++;
    end
    rd = xmove_rdata_o;
    if (cyc >= 60) begin
      error_cnt++;
      end_sim();
    end
  endtask
  initial begin
    {rst_i, sfr_wr_i, sfr_rd_i, rom_limit_wr_i, timed_access_i, fetch_req_i} = 6'h20;
    {dp_load_i, dp_inc_i, xmove_start_i, xmove_we_i, external_access_n_i} = 5'h01;
    {sfr_addr_i, sfr_wdata_i, xmove_wdata_i, fetch_addr_i} = 40'h0;
    {dp_load_val_i, xmove_addr_i, security_lock_bits_i} = 35'h0;
    repeat (6) step();
    rst_i = 1'b0;
    repeat (5) step();
    sfr_r(`ADDR_CLK_CTRL);
    `CHK("clock_control", 8'h01, rd)
    sfr_r(8'hC4);
    `CHK("power_management", 8'h00, rd)
    fchk(16'h3FFF, 1'b0);
    fchk(16'h4000, 1'b1);
    // No fetch is in flight while the limit moves.
    foreach (rows[i]) begin
      set_limit(rows[i][18:16], 1'b1);
      fchk(rows[i][15:0], rows[i][19]);
    end
    set_limit(3'h3, 1'b1);
    set_limit(3'h0, 1'b0);
    fchk(16'h0100, 1'b0);
    external_access_n_i = 1'b0;
    repeat (4) step();
    fchk(16'h0100, 1'b1);
    external_access_n_i = 1'b1;
    for (int s = 0; s < 8; s++) begin
      sfr_w(`ADDR_CLK_CTRL, s[7:0]);
      move(1'b1, 16'h1234, 8'h30 + s[7:0]);
      move(1'b0, 16'h1234, 8'h00);
      `CHK("ext_rdata", 8'h30 + s[7:0], rd)
      `CHK("strobe_width", (s > 0) ? 4 * s : 2, wid)
      `CHK("ext_cycles", 4 * (s + 2), cyc)
    end
    sfr_w(8'hC4, 8'h01);
    move(1'b1, 16'h0010, 8'h5A);
    `CHK("int_cycles", 8, cyc)
    `CHK("int_strobe", 0, wid)
    move(1'b0, 16'h0400, 8'h00);
    `CHK("above_sram", 28, wid)
    sfr_w(8'hC4, 8'h03);
    security_lock_bits_i = 3'h5;
    move(1'b0, 16'hFFFC, 8'h00);
    `CHK("lock_status", 8'h05, rd)
    move(1'b0, 16'h0500, 8'h00);
    `CHK("no_ext_access", 0, wid)
    move(1'b0, 16'h0010, 8'h00);
    `CHK("sram_kept", 8'h5A, rd)
    sfr_w(8'hC4, 8'h00);
    sfr_w(`ADDR_CLK_CTRL, 8'h00);
    // A stretch written mid-move must leave that move's width alone.
    fork
      move(1'b0, 16'h2000, 8'h00);
      begin
        repeat (3) step();
        sfr_w(`ADDR_CLK_CTRL, 8'h07);
      end
    join
    `CHK("width_held", 2, wid)
    sfr_w(`ADDR_DP0_LO, 8'h34);
    sfr_w(`ADDR_DP0_HI, 8'h12);
    sfr_w(`ADDR_DP1_LO, 8'hCD);
    sfr_w(`ADDR_DP1_HI, 8'hAB);
    sfr_w(`ADDR_PTR_SEL, 8'hFF);
    sfr_r(`ADDR_PTR_SEL);
    `CHK("select_read", 8'h01, rd)
    `CHK("pointer1", 16'hABCD, dp_active_o)
    dp_inc_i = 1'b1;
    step();
    dp_inc_i = 1'b0;
    sfr_r(`ADDR_DP1_LO);
    `CHK("pointer1_inc", 8'hCE, rd)
    sfr_w(`ADDR_PTR_SEL, 8'h00);
    `CHK("pointer0", 16'h1234, dp_active_o)
    {dp_load_i, dp_load_val_i} = {1'b1, 16'h5678};
    step();
    dp_load_i = 1'b0;
    `CHK("pointer0_load", 16'h5678, dp_active_o)
    end_sim();
  end
endmodule
bind memdec memdec_assertions chk (.*);
